/* hw/pbmux_pkg.sv */
package pbmux_pkg;
  localparam int PBMUX_NPINS = 6;
  localparam logic [1:0] PBMUX_ADDR_CONTROL = 2'h0;
  localparam logic [1:0] PBMUX_ADDR_LATCH = 2'h1;
  localparam logic [1:0] PBMUX_ADDR_DIR = 2'h2;
  localparam logic [7:0] PBMUX_RESET_VALUE = 8'h00;
  localparam logic [7:0] PBMUX_PORT_MASK = 8'h3f;
  // Bits 7 and 2 of the control register are reserved
  localparam logic [7:0] PBMUX_CONTROL_MASK = 8'h7b;
  localparam int PBMUX_PUD_BIT = 6;
  localparam int PBMUX_PIN_RESET = 5;
  localparam int PBMUX_PIN_CMP_B = 1;
  localparam int PBMUX_PIN_CMP_A = 0;
  localparam int PBMUX_PIN_EXT = 2;
  // Fuse bit value that means programmed
  localparam logic PBMUX_FUSE_PROGRAMMED = 1'b0;
endpackage

/* hw/pbmux_pin.sv */
`timescale 1ns/10ps
// One pad's control path after overrides are applied
module pbmux_pin (
  input wire logic dir_bit,
  input wire logic latch_bit,
  input wire logic global_pullup_disable,
  input wire logic sleep,
  input wire logic pullup_override_enable,
  input wire logic pullup_override_value,
  input wire logic direction_override_enable,
  input wire logic direction_override_value,
  input wire logic port_value_override_enable,
  input wire logic port_value_override_value,
  input wire logic input_enable_override_enable,
  input wire logic input_enable_override_value,
  output logic pull_up,
  output logic drive_en,
  output logic drive_val,
  output logic input_en
);
  always_comb begin
    pull_up = pullup_override_enable ? pullup_override_value : (!dir_bit && latch_bit && !global_pullup_disable); // [RULE_13]
    drive_en = direction_override_enable ? direction_override_value : dir_bit; // [RULE_14]
    drive_val = port_value_override_enable ? port_value_override_value : latch_bit; // [RULE_15]
    input_en = input_enable_override_enable ? input_enable_override_value : !sleep; // [RULE_16]
  end
endmodule

/* hw/pbmux_top.sv */
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01 - Control register bits 7 and 2 always read as zero.
// RULE_02 - Global pull-up disable set switches every default pull-up off.
// RULE_03 - A fuse term is one when its fuse bit is zero (programmed).
// RULE_04 - Pin 5 with both fuses programmed forces pull-up on, debug drive.
// RULE_05 - Pin 5 input override on fuse, mask and enable, or digital-off.
// RULE_06 - Pin 4 input override on mask and enable, or its digital-off.
// RULE_07 - Pin 3 input override on mask and enable, or its digital-off.
// RULE_08 - Pin 2 input override likewise; its input feeds timer and irq.
// RULE_09 - Pin 1 input override on mask and enable, or comparator neg off.
// RULE_10 - Pin 0 input override on mask and enable, or comparator pos off.
// RULE_11 - Enabled compare outputs B and A drive pins 1 and 0 value.
// RULE_12 - Latch and direction reset to zero, hold 5:0, read zero in 7:6.
// RULE_13 - Pull-up follows override, else on when dir,latch,pud = 010.
// RULE_14 - Driver enable follows direction override, else direction bit.
// RULE_15 - Enabled driver outputs override value instead of latch bit.
// RULE_16 - Input enable follows override, else inverse of controller sleep state.
module pbmux_top
  import pbmux_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic reset_pin_disable_fuse,
  input wire logic single_wire_debug_fuse,
  input wire logic debug_transmit,
  input wire logic [5:0] pin_change_mask,
  input wire logic pin_change_enable,
  input wire logic analog_ch_zero_digital_off,
  input wire logic analog_ch_one_digital_off,
  input wire logic analog_ch_two_digital_off,
  input wire logic analog_ch_three_digital_off,
  input wire logic comparator_pos_digital_off,
  input wire logic comparator_neg_digital_off,
  input wire logic compare_a_enable,
  input wire logic compare_a_wave_out,
  input wire logic compare_b_enable,
  input wire logic compare_b_wave_out,
  input wire logic sleep,
  input wire logic [5:0] pad_in,
  output logic [5:0] pad_out,
  output logic [5:0] pad_oe,
  output logic [5:0] pad_pullup,
  output logic [5:0] input_enable,
  output logic [5:0] alt_function_input_tap,
  output logic timer_ext_clock_in,
  output logic external_irq_zero_in
);
  import pbmux_pkg::*;

  logic rst_meta_n;
  logic rst_sync_n;
  logic outs_live;
  logic [7:0] micro_control;
  logic [7:0] port_output_latch;
  logic [7:0] port_direction;
  logic [5:0] pad_meta;
  logic [5:0] pad_sync;
  logic fuse_rst_prog;
  logic fuse_dbg_prog;
  logic both_fuses;
  logic [5:0] pullup_override_enable;
  logic [5:0] pullup_override_value;
  logic [5:0] direction_override_enable;
  logic [5:0] direction_override_value;
  logic [5:0] port_value_override_enable;
  logic [5:0] port_value_override_value;
  logic [5:0] input_enable_override_enable;
  logic [5:0] input_enable_override_value;
  logic [5:0] digital_off;
  logic [5:0] next_pull;
  logic [5:0] next_oe;
  logic [5:0] next_val;
  logic [5:0] next_ie;

  function automatic logic fuse_on(input logic fuse_bit);
    return fuse_bit == PBMUX_FUSE_PROGRAMMED; // [RULE_03]
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Outputs carry live values one edge after reset leaves; checks wait too
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      outs_live <= 1'b0;
    end else begin
      outs_live <= 1'b1;
    end
  end

  // Register writes
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      micro_control <= PBMUX_RESET_VALUE;
      port_output_latch <= PBMUX_RESET_VALUE;
      port_direction <= PBMUX_RESET_VALUE;
    end else if (wr_stb) begin
      case (addr)
        PBMUX_ADDR_CONTROL: begin
          micro_control <= wdata & PBMUX_CONTROL_MASK; // [RULE_01]
        end
        PBMUX_ADDR_LATCH: begin
          port_output_latch <= wdata & PBMUX_PORT_MASK; // [RULE_12]
        end
        PBMUX_ADDR_DIR: begin
          port_direction <= wdata & PBMUX_PORT_MASK; // [RULE_12]
        end
        default: begin
        end
      endcase
    end
  end

  // Read data in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata <= PBMUX_RESET_VALUE;
    end else if (rd_stb) begin
      case (addr)
        PBMUX_ADDR_CONTROL: rdata <= micro_control; // [RULE_01]
        PBMUX_ADDR_LATCH: rdata <= port_output_latch; // [RULE_12]
        PBMUX_ADDR_DIR: rdata <= port_direction; // [RULE_12]
        default: rdata <= PBMUX_RESET_VALUE;
      endcase
    end else begin
      rdata <= PBMUX_RESET_VALUE;
    end
  end

  // Pads are asynchronous; first stage is read only by the second
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pad_meta <= 6'h00;
      pad_sync <= 6'h00;
    end else begin
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
    end
  end

  always_comb begin
    fuse_rst_prog = fuse_on(reset_pin_disable_fuse);
    fuse_dbg_prog = fuse_on(single_wire_debug_fuse);
    both_fuses = fuse_rst_prog && fuse_dbg_prog;
    digital_off = {analog_ch_zero_digital_off, analog_ch_two_digital_off,
                   analog_ch_three_digital_off, analog_ch_one_digital_off,
                   comparator_neg_digital_off, comparator_pos_digital_off};
    pullup_override_enable = 6'h00;
    pullup_override_value = 6'h00;
    direction_override_enable = 6'h00;
    direction_override_value = 6'h00;
    port_value_override_enable = 6'h00;
    port_value_override_value = 6'h00;
    pullup_override_enable[PBMUX_PIN_RESET] = both_fuses; // [RULE_04]
    pullup_override_value[PBMUX_PIN_RESET] = 1'b1; // [RULE_04]
    direction_override_enable[PBMUX_PIN_RESET] = both_fuses; // [RULE_04]
    direction_override_value[PBMUX_PIN_RESET] = debug_transmit; // [RULE_04]
    port_value_override_enable[PBMUX_PIN_CMP_B] = compare_b_enable; // [RULE_11]
    port_value_override_value[PBMUX_PIN_CMP_B] = compare_b_wave_out; // [RULE_11]
    port_value_override_enable[PBMUX_PIN_CMP_A] = compare_a_enable; // [RULE_11]
    port_value_override_value[PBMUX_PIN_CMP_A] = compare_a_wave_out; // [RULE_11]
    // Pins 4..0 share one form: mask and enable, or digital-off
    input_enable_override_enable = (pin_change_mask & {6{pin_change_enable}}) // [RULE_06] [RULE_07]
            | digital_off; // [RULE_08] [RULE_09] [RULE_10]
    input_enable_override_enable[PBMUX_PIN_RESET] = fuse_rst_prog
        || (pin_change_mask[PBMUX_PIN_RESET] && pin_change_enable)
        || digital_off[PBMUX_PIN_RESET]; // [RULE_05]
    input_enable_override_value = digital_off; // [RULE_05] [RULE_06] [RULE_09] [RULE_10]
  end

  for (genvar i = 0; i < PBMUX_NPINS; i++) begin : g_pin
    pbmux_pin u_pin (
      .dir_bit(port_direction[i]),
      .latch_bit(port_output_latch[i]),
      .global_pullup_disable(micro_control[PBMUX_PUD_BIT]), // [RULE_02]
      .sleep(sleep),
      .pullup_override_enable(pullup_override_enable[i]),
      .pullup_override_value(pullup_override_value[i]),
      .direction_override_enable(direction_override_enable[i]),
      .direction_override_value(direction_override_value[i]),
      .port_value_override_enable(port_value_override_enable[i]),
      .port_value_override_value(port_value_override_value[i]),
      .input_enable_override_enable(input_enable_override_enable[i]),
      .input_enable_override_value(input_enable_override_value[i]),
      .pull_up(next_pull[i]),
      .drive_en(next_oe[i]),
      .drive_val(next_val[i]),
      .input_en(next_ie[i])
    );
  end

  // Registered pad controls; pads tri-stated during reset
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pad_out <= 6'h00;
      pad_oe <= 6'h00;
      pad_pullup <= 6'h00;
      input_enable <= 6'h00;
    end else begin
      pad_out <= next_val; // [RULE_15]
      pad_oe <= next_oe; // [RULE_14]
      pad_pullup <= next_pull; // [RULE_13] [RULE_02]
      input_enable <= next_ie; // [RULE_16]
    end
  end

  // Synchronised taps; disabled input reads as zero (clamped)
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      alt_function_input_tap <= 6'h00;
      timer_ext_clock_in <= 1'b0;
      external_irq_zero_in <= 1'b0;
    end else begin
      alt_function_input_tap <= pad_sync & next_ie;
      timer_ext_clock_in <= pad_sync[PBMUX_PIN_EXT]
                            & next_ie[PBMUX_PIN_EXT]; // [RULE_08]
      external_irq_zero_in <= pad_sync[PBMUX_PIN_EXT]
                              & next_ie[PBMUX_PIN_EXT]; // [RULE_08]
    end
  end

  property p_pud_kills_pullup;
    @(posedge clk) disable iff (!outs_live)
    (micro_control[PBMUX_PUD_BIT] && !both_fuses) |=> (pad_pullup == 6'h00);
  endproperty
  a_pud_kills_pullup: assert property (p_pud_kills_pullup) // [RULE_02]
    else $error("pull-up on while global disable set");

  property p_ctrl_reserved;
    @(posedge clk) disable iff (!outs_live)
    $past(rd_stb) && $past(addr) == PBMUX_ADDR_CONTROL
      |-> (rdata[7] == 1'b0 && rdata[2] == 1'b0);
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) // [RULE_01]
    else $error("reserved control bit read as one");

  property p_debug_pin;
    @(posedge clk) disable iff (!outs_live)
    (!reset_pin_disable_fuse && !single_wire_debug_fuse)
      |=> (pad_pullup[5] && pad_oe[5] == $past(debug_transmit));
  endproperty
  a_debug_pin: assert property (p_debug_pin) // [RULE_04]
    else $error("debug pin not forced");

  property p_fuse_unprog;
    @(posedge clk) disable iff (!outs_live)
    (reset_pin_disable_fuse && !pin_change_enable
      && !analog_ch_zero_digital_off && !sleep) |=> input_enable[5];
  endproperty
  a_fuse_unprog: assert property (p_fuse_unprog) // [RULE_03]
    else $error("unprogrammed fuse acted");

  property p_pin5_ie;
    @(posedge clk) disable iff (!outs_live)
    (!reset_pin_disable_fuse && !analog_ch_zero_digital_off)
      |=> !input_enable[5];
  endproperty
  a_pin5_ie: assert property (p_pin5_ie) // [RULE_05]
    else $error("pin 5 input not disabled by fuse");

  property p_pin4_ie;
    @(posedge clk) disable iff (!outs_live)
    analog_ch_two_digital_off |=> input_enable[4];
  endproperty
  a_pin4_ie: assert property (p_pin4_ie) // [RULE_06]
    else $error("pin 4 input not following its override value");

  property p_pin3_ie;
    @(posedge clk) disable iff (!outs_live)
    (pin_change_mask[3] && pin_change_enable && !analog_ch_three_digital_off)
      |=> !input_enable[3];
  endproperty
  a_pin3_ie: assert property (p_pin3_ie) // [RULE_07]
    else $error("pin 3 input not following its override value");

  property p_pin2_ie;
    @(posedge clk) disable iff (!outs_live)
    analog_ch_one_digital_off |=> input_enable[PBMUX_PIN_EXT]
      && timer_ext_clock_in == $past(pad_sync[PBMUX_PIN_EXT])
      && external_irq_zero_in == $past(pad_sync[PBMUX_PIN_EXT]);
  endproperty
  a_pin2_ie: assert property (p_pin2_ie) // [RULE_08]
    else $error("pin 2 input or its taps not following the pad");

  property p_pin1_ie;
    @(posedge clk) disable iff (!outs_live)
    comparator_neg_digital_off |=> input_enable[1];
  endproperty
  a_pin1_ie: assert property (p_pin1_ie) // [RULE_09]
    else $error("pin 1 input not following its override value");

  property p_pin0_ie;
    @(posedge clk) disable iff (!outs_live)
    comparator_pos_digital_off |=> input_enable[0];
  endproperty
  a_pin0_ie: assert property (p_pin0_ie) // [RULE_10]
    else $error("pin 0 input not following its override value");

  property p_cmp_b;
    @(posedge clk) disable iff (!outs_live)
    compare_b_enable |=> pad_out[1] == $past(compare_b_wave_out);
  endproperty
  a_cmp_b: assert property (p_cmp_b) // [RULE_11]
    else $error("pin 1 not following compare B");

  sequence s_dir_write;
    wr_stb && addr == PBMUX_ADDR_DIR;
  endsequence
  property p_dir_drive;
    @(posedge clk) disable iff (!outs_live)
    s_dir_write ##1 !wr_stb && !both_fuses
      |=> pad_oe[4:0] == port_direction[4:0];
  endproperty
  a_dir_drive: assert property (p_dir_drive) // [RULE_14]
    else $error("driver enable not following direction");

  property p_default_pull;
    @(posedge clk) disable iff (!outs_live)
    (!port_direction[3] && port_output_latch[3]
      && !micro_control[PBMUX_PUD_BIT]) |=> pad_pullup[3];
  endproperty
  a_default_pull: assert property (p_default_pull) // [RULE_13]
    else $error("default pull-up missing");

  property p_latch_hi;
    @(posedge clk) disable iff (!outs_live)
    $past(rd_stb) && $past(addr) != PBMUX_ADDR_CONTROL
      |-> rdata[7:6] == 2'b00;
  endproperty
  a_latch_hi: assert property (p_latch_hi) // [RULE_12]
    else $error("latch or direction upper bits read as one");

  property p_sleep_ie;
    @(posedge clk) disable iff (!outs_live)
    (sleep && !pin_change_enable && !analog_ch_two_digital_off)
      |=> !input_enable[4];
  endproperty
  a_sleep_ie: assert property (p_sleep_ie) // [RULE_16]
    else $error("input enabled in sleep");

  property p_latch_value;
    @(posedge clk) disable iff (!outs_live)
    (port_direction[2]) |=> pad_out[2] == $past(port_output_latch[2]);
  endproperty
  a_latch_value: assert property (p_latch_value) // [RULE_15]
    else $error("pin 2 value not from latch");
endmodule

/* test/pbmux_periph.sv */
`timescale 1ns/10ps
// Peripheral side: fuses, pin-change, analog, timer and sleep sources.
// Purely static levels; the bench steps cfg just after a clock edge.
module pbmux_periph (
  input wire logic [20:0] cfg,
  output logic reset_pin_disable_fuse,
  output logic single_wire_debug_fuse,
  output logic debug_transmit,
  output logic [5:0] pin_change_mask,
  output logic pin_change_enable,
  output logic comparator_pos_digital_off,
  output logic comparator_neg_digital_off,
  output logic analog_ch_one_digital_off,
  output logic analog_ch_three_digital_off,
  output logic analog_ch_two_digital_off,
  output logic analog_ch_zero_digital_off,
  output logic compare_a_enable,
  output logic compare_a_wave_out,
  output logic compare_b_enable,
  output logic compare_b_wave_out,
  output logic sleep
);
  // Digital-off bits are packed by pin index, 5 down to 0
  assign {sleep, compare_b_wave_out, compare_b_enable, compare_a_wave_out,
          compare_a_enable, analog_ch_zero_digital_off,
          analog_ch_two_digital_off, analog_ch_three_digital_off,
          analog_ch_one_digital_off, comparator_neg_digital_off,
          comparator_pos_digital_off, pin_change_enable, pin_change_mask,
          debug_transmit, single_wire_debug_fuse,
          reset_pin_disable_fuse} = cfg;
endmodule

/* test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import pbmux_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [20:0] cfg = 21'h0_0003;
  logic [5:0] pad_in = 6'h00;
  logic [7:0] rdata;
  logic [5:0] pad_out, pad_oe, pad_pullup, input_enable;
  logic [5:0] alt_function_input_tap, pin_change_mask;
  logic timer_ext_clock_in, external_irq_zero_in, sleep;
  logic reset_pin_disable_fuse, single_wire_debug_fuse, debug_transmit;
  logic pin_change_enable, compare_a_enable, compare_a_wave_out;
  logic compare_b_enable, compare_b_wave_out, analog_ch_zero_digital_off;
  logic analog_ch_one_digital_off, analog_ch_two_digital_off;
  logic analog_ch_three_digital_off, comparator_pos_digital_off;
  logic comparator_neg_digital_off;
  logic [23:0] e;
  logic [23:0] pads;
  logic [7:0] taps;
  logic [7:0] te;
  localparam logic [23:0] M_PU = 24'hfc_0000;
  localparam logic [23:0] M_OE = 24'h03_f000;
  localparam logic [23:0] M_OV = 24'h00_0fc0;
  localparam logic [23:0] M_HI = 24'h00_0038;
  localparam logic [23:0] M_LO = 24'h00_0007;
  // Value only matters while the driver is on
  assign pads = {pad_pullup, pad_oe, pad_out & pad_oe, input_enable};
  assign taps = {alt_function_input_tap, timer_ext_clock_in,
                 external_irq_zero_in};
  int failures = 0;
  int compares = 0;
  // Register table entries: {pud, direction, latch}
  logic [20:0] tcfg [8] = '{21'h0_0003, 21'h0_0003, 21'h0_0004, 21'h0_0000,
    21'h7_0003, 21'h10_aaab, 21'h10_14aa, 21'h0_01fb};
  logic [12:0] treg [8] = '{13'h003f, 13'h103f, 13'h103f, 13'h081f,
    13'h0fea, 13'h0015, 13'h0020, 13'h057f};

  always #4 clk = ~clk;

  pbmux_periph pbmux_periph_i (.cfg, .reset_pin_disable_fuse,
    .single_wire_debug_fuse, .debug_transmit, .pin_change_mask,
    .pin_change_enable, .comparator_pos_digital_off,
    .comparator_neg_digital_off, .analog_ch_one_digital_off,
    .analog_ch_three_digital_off, .analog_ch_two_digital_off,
    .analog_ch_zero_digital_off, .compare_a_enable, .compare_a_wave_out,
    .compare_b_enable, .compare_b_wave_out, .sleep);

  pbmux_top pbmux_top_i (.clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .reset_pin_disable_fuse, .single_wire_debug_fuse,
    .debug_transmit, .pin_change_mask, .pin_change_enable,
    .analog_ch_zero_digital_off, .analog_ch_one_digital_off,
    .analog_ch_two_digital_off, .analog_ch_three_digital_off,
    .comparator_pos_digital_off, .comparator_neg_digital_off,
    .compare_a_enable, .compare_a_wave_out, .compare_b_enable,
    .compare_b_wave_out, .sleep, .pad_in, .pad_out, .pad_oe, .pad_pullup,
    .input_enable, .alt_function_input_tap, .timer_ext_clock_in,
    .external_irq_zero_in);

  task automatic chk(string name, logic [23:0] seen, logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [1:0] a, logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk("rdata", {16'h0000, rdata}, {16'h0000, exp});
  endtask

  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Returns {pullup, oe, out masked by oe, input enable}
  function automatic logic [23:0] exp_pins(logic [20:0] c, logic [12:0] r);
    logic [5:0] pu, oe, ov, ie;
    logic rp, dp;
    rp = (c[0] == PBMUX_FUSE_PROGRAMMED);
    dp = (c[1] == PBMUX_FUSE_PROGRAMMED);
    for (int i = 0; i < 6; i++) begin
      pu[i] = ~r[6+i] & r[i] & ~r[12];
      oe[i] = r[6+i];
      ov[i] = r[i];
      ie[i] = ((c[3+i] & c[9]) | c[10+i]) ? c[10+i] : ~c[20];
    end
    if (rp & dp) begin
      pu[5] = 1'b1;
      oe[5] = c[2];
    end
    if (rp) ie[5] = c[15];
    if (c[18]) ov[1] = c[19];
    if (c[16]) ov[0] = c[17];
    return {pu, oe, ov & oe, ie};
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude;
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("reset", pads, 24'h0);
    chk("reset_out", {18'h0, pad_out}, 24'h0);
    repeat (3) @(posedge clk);
    rd(PBMUX_ADDR_LATCH, 8'h00);
    rd(PBMUX_ADDR_DIR, 8'h00);
    wr(PBMUX_ADDR_LATCH, 8'hff);
    wr(PBMUX_ADDR_DIR, 8'hff);
    wr(PBMUX_ADDR_CONTROL, 8'hff);
    wr(2'h3, 8'h00);
    rd(PBMUX_ADDR_LATCH, 8'h3f);
    rd(PBMUX_ADDR_DIR, 8'h3f);
    rd(PBMUX_ADDR_CONTROL, 8'h7b);
    rd(2'h3, 8'h00);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      cfg <= tcfg[k];
      pad_in <= 6'h2d ^ {6{k[0]}};
      wr(PBMUX_ADDR_CONTROL, {1'b0, treg[k][12], 6'h00});
      wr(PBMUX_ADDR_LATCH, {2'b00, treg[k][5:0]});
      wr(PBMUX_ADDR_DIR, {2'b00, treg[k][11:6]});
      repeat (4) @(posedge clk);
      #1 e = exp_pins(tcfg[k], treg[k]);
      te = {pad_in & e[5:0], {2{pad_in[2] & e[2]}}};
      chk("pullup", pads & M_PU, e & M_PU);
      chk("oe", pads & M_OE, e & M_OE);
      chk("out", pads & M_OV, e & M_OV);
      chk("in_hi", pads & M_HI, e & M_HI);
      chk("in_lo", pads & M_LO, e & M_LO);
      chk("taps", {16'h0000, taps}, {16'h0000, te});
    end
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("reset", pads, 24'h0);
    chk("reset_out", {18'h0, pad_out}, 24'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(PBMUX_ADDR_LATCH, 8'h00);
    rd(PBMUX_ADDR_DIR, 8'h00);
    conclude;
  end
endmodule
